// file: include/dcg_pkg.sv
// Purpose: Shared constants and types of the dual oscillator clock generator
// Assumes: Control register bits are plain ports, no bus
// Notes: Bit positions follow the processor clock control register layout
package dcg_pkg;
   // Processor clock control register
   localparam logic [7:0] CTRL_RESET = 8'h04;
   localparam int DIV_LSB = 0;
   localparam int DIV_MSB = 2;
   localparam int SRC_SEL_BIT = 4;
   localparam int STATUS_BIT = 5;
   localparam int FB_DIS_BIT = 6;
   localparam int OSC_STOP_BIT = 7;
   // Writable bits: status bit 5 and unused bit 3 are not stored
   localparam logic [7:0] CTRL_WR_MASK = 8'hd7;

   // CPU and peripheral clock division
   localparam logic [2:0] DIV_SLOWEST = 3'h4;
   localparam int DIV_STAGES = 5;
   localparam logic [4:0] DIV_MAX_MASK = 5'h1f;

   // Old-clock CPU ticks run before a new selection takes hold
   localparam logic [7:0] SWITCH_DELAY_INSTR = 8'h10;

   typedef enum logic [2:0] {
      DCG_RUN  = 3'h1,
      DCG_HALT = 3'h2,
      DCG_STOP = 3'h4
   } dcg_mode_e;
endpackage

// file: hdl/dcg_edge_sync.sv
// Purpose: Brings an oscillator pin into the reference domain, flags rising edges
// Assumes: Pin toggles well below half the reference rate
// Notes: First stage feeds only the second stage
`timescale 1ns/10ps
module dcg_edge_sync (
   input wire logic i_ref_clk,
   input wire logic i_reset,
   input wire logic i_pin,
   output logic o_rise
);
   typedef struct packed {
      logic meta;
      logic sync;
      logic prev;
      logic rise;
   } dcg_sync_s;

   dcg_sync_s s_r;
   dcg_sync_s s_nxt;

   always_comb begin
      s_nxt = s_r;
      s_nxt.meta = i_pin;
      s_nxt.sync = s_r.meta;
      s_nxt.prev = s_r.sync;
      s_nxt.rise = s_r.sync & ~s_r.prev;
   end

   always_ff @(posedge i_ref_clk) begin
      if (i_reset) begin
         s_r <= '0;
      end else begin
         s_r <= s_nxt;
      end
   end

   assign o_rise = s_r.rise;
endmodule

// file: hdl/dcg_prescaler.sv
// Purpose: Divides main clock ticks into a ladder of peripheral ticks
// Assumes: i_tick is a one-cycle pulse per main clock period
// Notes: Stage k ticks once every 2^(k+1) main clocks
`timescale 1ns/10ps
module dcg_prescaler #(
   parameter int STAGES = dcg_pkg::DIV_STAGES
) (
   input wire logic i_ref_clk,
   input wire logic i_reset,
   input wire logic i_tick,
   input wire logic i_run,
   output logic [STAGES-1:0] o_tick
);
   typedef struct packed {
      logic [STAGES-1:0] cnt;
      logic [STAGES-1:0] tick;
   } dcg_pre_s;

   dcg_pre_s s_r;
   dcg_pre_s s_nxt;
   logic [STAGES-1:0] tick_w;

   genvar k;
   generate
      for (k = 0; k < STAGES; k++) begin : g_stage
         assign tick_w[k] = i_tick & i_run & (&s_r.cnt[k:0]);
      end
   endgenerate

   always_comb begin
      s_nxt = s_r;
      s_nxt.tick = tick_w;
      if (!i_run) begin
         s_nxt.cnt = '0;
      end else if (i_tick) begin
         s_nxt.cnt = s_r.cnt + STAGES'(1);
      end
   end

   always_ff @(posedge i_ref_clk) begin
      if (i_reset) begin
         s_r <= '0;
      end else begin
         s_r <= s_nxt;
      end
   end

   assign o_tick = s_r.tick;
endmodule

// file: hdl/dcg_clock_gen.sv
// Purpose: Clock generator core: CPU clock selection, division, standby and oscillator stop
// Assumes: Both oscillator pins are slow against i_ref_clk; ticks are enable pulses
// Notes: Functional notes
`timescale 1ns/10ps
module dcg_clock_gen #(
   parameter logic [7:0] SWITCH_DELAY = dcg_pkg::SWITCH_DELAY_INSTR
) (
   input wire logic i_ref_clk,
   input wire logic i_reset,
   input wire logic i_main_osc_in,
   input wire logic i_sub_osc_in,
   input wire logic i_ctrl_wr,
   input wire logic [7:0] i_ctrl_wdata,
   output logic [7:0] o_ctrl_rdata,
   input wire logic i_stop_req,
   input wire logic i_halt_req,
   input wire logic i_wake,
   output logic o_stop_refused,
   output logic o_stop_mode,
   output logic o_halt_mode,
   output logic o_main_osc_enable,
   output logic o_main_osc_out,
   output logic o_main_osc_out_oe_n,
   output logic o_feedback_resistor_disable,
   output logic o_active_clock_status,
   output logic o_cpu_tick,
   output logic [dcg_pkg::DIV_STAGES-1:0] o_periph_tick,
   output logic o_watch_tick,
   output logic o_clkout_tick,
   output logic o_wdt_count_en
);
   typedef struct packed {
      dcg_pkg::dcg_mode_e mode;
      logic [7:0] ctrl;
      logic on_sub;
      logic [2:0] div_act;
      logic pend;
      logic [7:0] pend_cnt;
      logic [4:0] cpu_cnt;
      logic cpu_tick;
      logic sub_tick;
   } dcg_state_s;

   localparam dcg_state_s RESET_STATE = '{
      mode: dcg_pkg::DCG_RUN,
      ctrl: dcg_pkg::CTRL_RESET,
      on_sub: 1'h0,
      div_act: dcg_pkg::DIV_SLOWEST,
      pend: 1'h0,
      pend_cnt: 8'h00,
      cpu_cnt: 5'h00,
      cpu_tick: 1'h0,
      sub_tick: 1'h0
   };

   dcg_state_s s_r;
   dcg_state_s s_nxt;
   logic main_rise;
   logic sub_rise;
   logic osc_run;
   logic main_tick;
   logic tick_raw;
   logic [2:0] div_eff;
   logic [4:0] cpu_limit;

   // Pin pairs carry one clock and its complement; only the first pin is sampled
   dcg_edge_sync u_main_sync (
      .i_ref_clk(i_ref_clk),
      .i_reset(i_reset),
      .i_pin(i_main_osc_in),
      .o_rise(main_rise)
   );

   dcg_edge_sync u_sub_sync (
      .i_ref_clk(i_ref_clk),
      .i_reset(i_reset),
      .i_pin(i_sub_osc_in),
      .o_rise(sub_rise)
   );

   // Main oscillation stops in reset, in stop standby, or once the stop bit
   // meets subsystem operation
   assign osc_run = ~(i_reset
      | (s_r.on_sub & s_r.ctrl[dcg_pkg::OSC_STOP_BIT])
      | (s_r.mode == dcg_pkg::DCG_STOP));
   assign main_tick = main_rise & osc_run;

   // Peripheral ladder runs from main ticks only
   dcg_prescaler #(
      .STAGES(dcg_pkg::DIV_STAGES)
   ) u_prescaler (
      .i_ref_clk(i_ref_clk),
      .i_reset(i_reset),
      .i_tick(main_tick),
      .i_run(osc_run),
      .o_tick(o_periph_tick)
   );

   // Reserved encodings fall back to the slowest division
   assign div_eff = (s_r.div_act > dcg_pkg::DIV_SLOWEST) ? dcg_pkg::DIV_SLOWEST
                                                          : s_r.div_act;
   assign cpu_limit = dcg_pkg::DIV_MAX_MASK >> (dcg_pkg::DIV_SLOWEST - div_eff);

   always_comb begin
      s_nxt = s_r;
      tick_raw = 1'h0;
      s_nxt.cpu_tick = 1'h0;
      s_nxt.sub_tick = sub_rise;

      // CPU clock from the active source
      if (s_r.on_sub) begin
         tick_raw = sub_rise;
      end else if (main_tick) begin
         if (s_r.cpu_cnt >= cpu_limit) begin
            s_nxt.cpu_cnt = 5'h00;
            tick_raw = 1'h1;
         end else begin
            s_nxt.cpu_cnt = s_r.cpu_cnt + 5'h01;
         end
      end
      s_nxt.cpu_tick = tick_raw & (s_r.mode == dcg_pkg::DCG_RUN);

      // Switchover lands on an old-clock tick and restarts the new divider,
      // so neither the last old period nor a first new main-clock period is cut short; a first subsystem period can be
      if (s_r.pend && tick_raw && (s_r.mode == dcg_pkg::DCG_RUN)) begin
         if (s_r.pend_cnt <= 8'h01) begin
            s_nxt.pend = 1'h0;
            s_nxt.pend_cnt = 8'h00;
            s_nxt.on_sub = s_r.ctrl[dcg_pkg::SRC_SEL_BIT];
            s_nxt.div_act = s_r.ctrl[dcg_pkg::DIV_MSB:dcg_pkg::DIV_LSB];
            s_nxt.cpu_cnt = 5'h00;
         end else begin
            s_nxt.pend_cnt = s_r.pend_cnt - 8'h01;
         end
      end

      // A write restarts the wait; the status bit is not writable
      // A write landing on a switch cycle supersedes that switch: last write wins
      if (i_ctrl_wr) begin
         s_nxt.ctrl = i_ctrl_wdata & dcg_pkg::CTRL_WR_MASK;
         s_nxt.on_sub = s_r.on_sub;
         s_nxt.div_act = s_r.div_act;
         s_nxt.pend = 1'h1;
         s_nxt.pend_cnt = SWITCH_DELAY;
      end

      // Standby control
      case (s_r.mode)
         dcg_pkg::DCG_RUN: begin
            if (i_stop_req && !s_r.on_sub) begin
               s_nxt.mode = dcg_pkg::DCG_STOP;
            end else if (i_halt_req) begin
               s_nxt.mode = dcg_pkg::DCG_HALT;
            end
         end
         dcg_pkg::DCG_HALT: begin
            if (i_wake) begin
               s_nxt.mode = dcg_pkg::DCG_RUN;
            end
         end
         dcg_pkg::DCG_STOP: begin
            if (i_wake) begin
               s_nxt.mode = dcg_pkg::DCG_RUN;
            end
         end
         default: begin
            s_nxt.mode = dcg_pkg::DCG_RUN;
         end
      endcase
   end

   always_ff @(posedge i_ref_clk) begin
      if (i_reset) begin
         s_r <= RESET_STATE;
      end else begin
         s_r <= s_nxt;
      end
   end

   // Stop standby is refused while the subsystem clock is active
   assign o_stop_refused = i_stop_req & s_r.on_sub & (s_r.mode == dcg_pkg::DCG_RUN);
   assign o_stop_mode = (s_r.mode == dcg_pkg::DCG_STOP);
   assign o_halt_mode = (s_r.mode == dcg_pkg::DCG_HALT);
   assign o_ctrl_rdata = {s_r.ctrl[7:6], s_r.on_sub, s_r.ctrl[4:0]};
   assign o_active_clock_status = s_r.on_sub;
   assign o_main_osc_enable = osc_run;
   // Second main pin is pulled high only while main oscillation is stopped
   assign o_main_osc_out = 1'h1;
   assign o_main_osc_out_oe_n = osc_run;
   assign o_feedback_resistor_disable = s_r.ctrl[dcg_pkg::FB_DIS_BIT];
   assign o_cpu_tick = s_r.cpu_tick;
   assign o_watch_tick = s_r.sub_tick;
   assign o_clkout_tick = s_r.sub_tick;
   assign o_wdt_count_en = ~s_r.on_sub;

   // ---------------- Assertions ----------------
   default clocking cb @(posedge i_ref_clk);
   endclocking
   default disable iff (i_reset);

   sequence s_write_taken;
      i_ctrl_wr;
   endsequence

   sequence s_sub_edge_running;
      s_r.on_sub && sub_rise && (s_r.mode == dcg_pkg::DCG_RUN);
   endsequence

   sequence s_main_stop_active;
      s_r.on_sub && s_r.ctrl[dcg_pkg::OSC_STOP_BIT];
   endsequence

   property p_reset_value;
      $past(i_reset) |-> (o_ctrl_rdata == dcg_pkg::CTRL_RESET) && !o_active_clock_status;
   endproperty
   a_reset_value: assert property (p_reset_value)
      else $error("control register not at reset value after reset");

   property p_osc_off_in_reset;
      @(posedge i_ref_clk) disable iff (1'h0)
      i_reset |-> !o_main_osc_enable && !o_main_osc_out_oe_n;
   endproperty
   a_osc_off_in_reset: assert property (p_osc_off_in_reset)
      else $error("main oscillation enabled during reset");

   property p_mcc_deferred;
      (!o_active_clock_status && (s_r.mode != dcg_pkg::DCG_STOP))
         |-> o_main_osc_enable;
   endproperty
   a_mcc_deferred: assert property (p_mcc_deferred)
      else $error("main oscillation stopped while main clock active");

   property p_mcc_effect;
      s_main_stop_active |-> !o_main_osc_enable && !o_main_osc_out_oe_n ##1
         (o_periph_tick == '0);
   endproperty
   a_mcc_effect: assert property (p_mcc_effect)
      else $error("main oscillation not halted on subsystem with stop bit");

   property p_sub_cpu_tick;
      s_sub_edge_running |=> o_cpu_tick;
   endproperty
   a_sub_cpu_tick: assert property (p_sub_cpu_tick)
      else $error("subsystem edge did not give a CPU tick");

   property p_no_stop_on_sub;
      (s_r.on_sub && i_stop_req && (s_r.mode == dcg_pkg::DCG_RUN))
         |-> o_stop_refused ##1 !o_stop_mode;
   endproperty
   a_no_stop_on_sub: assert property (p_no_stop_on_sub)
      else $error("stop standby entered on subsystem clock");

   property p_wdt_stopped;
      o_active_clock_status |-> !o_wdt_count_en;
   endproperty
   a_wdt_stopped: assert property (p_wdt_stopped)
      else $error("watchdog counting on subsystem clock");

   property p_write_pending;
      s_write_taken |=> s_r.pend && (s_r.pend_cnt == SWITCH_DELAY)
         && !$changed(o_active_clock_status);
   endproperty
   a_write_pending: assert property (p_write_pending)
      else $error("write applied without switchover delay");

   property p_switch_on_tick;
      $changed(o_active_clock_status) |-> $past(tick_raw) && $past(s_r.pend)
         && (s_r.cpu_cnt == 5'h00);
   endproperty
   a_switch_on_tick: assert property (p_switch_on_tick)
      else $error("source switched away from a CPU tick boundary");

   property p_watch_in_standby;
      (sub_rise && (s_r.mode != dcg_pkg::DCG_RUN)) |=> o_watch_tick && o_clkout_tick;
   endproperty
   a_watch_in_standby: assert property (p_watch_in_standby)
      else $error("watch tick lost in standby");

   property p_frc_follows;
      $past(i_ctrl_wr) |-> o_feedback_resistor_disable
         == $past(i_ctrl_wdata[dcg_pkg::FB_DIS_BIT]);
   endproperty
   a_frc_follows: assert property (p_frc_follows)
      else $error("feedback disable does not follow written bit");

   property p_main_div_tick;
      (!s_r.on_sub && main_tick && (s_r.cpu_cnt == cpu_limit)
         && (s_r.mode == dcg_pkg::DCG_RUN)) |=> o_cpu_tick;
   endproperty
   a_main_div_tick: assert property (p_main_div_tick)
      else $error("main divider terminal count gave no CPU tick");

   sequence s_in_standby;
      s_r.mode != dcg_pkg::DCG_RUN;
   endsequence

   // Either standby holds the CPU clock off
   property p_no_cpu_in_standby;
      s_in_standby |=> !o_cpu_tick;
   endproperty
   a_no_cpu_in_standby: assert property (p_no_cpu_in_standby)
      else $error("CPU tick during standby");

   // Peripheral ladder is silent one cycle after main oscillation stops
   property p_periph_stop;
      !o_main_osc_enable |=> (o_periph_tick == '0);
   endproperty
   a_periph_stop: assert property (p_periph_stop)
      else $error("peripheral tick with main oscillation stopped");

   // Main edges alone never tick the CPU on the subsystem clock
   property p_sub_ignores_div;
      (s_r.on_sub && main_tick && !sub_rise && (s_r.mode == dcg_pkg::DCG_RUN))
         |=> !o_cpu_tick;
   endproperty
   a_sub_ignores_div: assert property (p_sub_ignores_div)
      else $error("main divider ticked CPU on subsystem clock");

   // Stopped main oscillator leaves the second pin driven high
   property p_osc_pin_pulled;
      !o_main_osc_enable |-> !o_main_osc_out_oe_n && o_main_osc_out;
   endproperty
   a_osc_pin_pulled: assert property (p_osc_pin_pulled)
      else $error("second main pin not pulled high while stopped");
endmodule

// file: verif/dcg_osc_model.sv
// Purpose: Oscillator sources on the main and subsystem pin pairs
// Assumes: Main oscillation runs only while the device enables it
// Notes: Pins change 2 ns off the reference edges
`timescale 1ns/10ps
module dcg_osc_model #(
   parameter int MAIN_HALF = 30,
   parameter int SUB_HALF = 200
) (
   input wire logic i_main_enable,
   output logic o_main_in,
   output logic o_main_in_n,
   output logic o_sub_in,
   output logic o_sub_in_n
);
   initial begin
      o_main_in = 1'b0;
      o_sub_in = 1'b0;
      #2;
      fork
         forever begin
            #(MAIN_HALF);
            // A stopped resonator rests low
            o_main_in = i_main_enable ? ~o_main_in : 1'b0;
         end
         forever begin
            #(SUB_HALF);
            o_sub_in = ~o_sub_in;
         end
      join
   end
   assign o_main_in_n = ~o_main_in;
   assign o_sub_in_n = ~o_sub_in;
endmodule

// file: verif/test_dcg_clock_gen.sv
// Purpose: Self-checking bench of the clock generator core
// Assumes: Main pin period 6 reference cycles, subsystem period 40
// Notes: Switch delay shortened to 2 CPU ticks
`timescale 1ns/10ps
module test_dcg_clock_gen;
   logic i_ref_clk = 1'b0;
   logic i_reset = 1'b1;
   logic i_ctrl_wr = 1'b0;
   logic [7:0] i_ctrl_wdata = 8'h00;
   logic i_stop_req = 1'b0;
   logic i_halt_req = 1'b0;
   logic i_wake = 1'b0;
   logic main_in, sub_in;
   logic [7:0] rdata;
   logic refused, stop_md, halt_md, osc_en, oe_n, frd, status, cpu, watch, clkout, wdt;
   logic [4:0] periph;
   int n_fail = 0;
   int n_tests = 0;
   int cyc = 0;
   int n;
   dcg_osc_model osc (.i_main_enable(osc_en), .o_main_in(main_in), .o_main_in_n(),
      .o_sub_in(sub_in), .o_sub_in_n());
   dcg_clock_gen #(.SWITCH_DELAY(8'h02)) dut (.i_ref_clk(i_ref_clk), .i_reset(i_reset),
      .i_main_osc_in(main_in), .i_sub_osc_in(sub_in), .i_ctrl_wr(i_ctrl_wr),
      .i_ctrl_wdata(i_ctrl_wdata), .o_ctrl_rdata(rdata), .i_stop_req(i_stop_req),
      .i_halt_req(i_halt_req), .i_wake(i_wake), .o_stop_refused(refused),
      .o_stop_mode(stop_md), .o_halt_mode(halt_md), .o_main_osc_enable(osc_en),
      .o_main_osc_out(), .o_main_osc_out_oe_n(oe_n), .o_feedback_resistor_disable(frd),
      .o_active_clock_status(status), .o_cpu_tick(cpu), .o_periph_tick(periph),
      .o_watch_tick(watch), .o_clkout_tick(clkout), .o_wdt_count_en(wdt));
   initial begin
      forever #5 i_ref_clk = ~i_ref_clk;
   end
   task automatic wrap_up();
      if (n_fail == 0 && n_tests > 0) begin
         $display("TB: PASS");
      end else begin
         $display("TB: FAIL");
      end
      $finish;
   endtask
   always @(posedge i_ref_clk) begin
      cyc++;
      if (cyc == 60000) begin
         n_fail++;
         wrap_up();
      end
   end
   task automatic chk(input logic [7:0] got, input logic [7:0] exp, input string msg);
      n_tests++;
      if (got !== exp) begin
         n_fail++;
         $display("BAD %0t %s got %h exp %h", $time, msg, got, exp);
      end
   endtask
   task automatic chk_n(input int got, input int exp, input string msg);
      n_tests++;
      if (got != exp) begin
         n_fail++;
         $display("BAD %0t %s got %0d exp %0d", $time, msg, got, exp);
      end
   endtask
   function automatic bit sig(input int sel);
      case (sel)
         5: return cpu === 1'b1;
         6: return watch === 1'b1;
         7: return clkout === 1'b1;
         default: return periph[sel] === 1'b1;
      endcase
   endfunction
   // Cycles between two pulses of the chosen tick
   task automatic gap(input int sel, output int g);
      int k;
      k = 0;
      g = 0;
      do begin
         @(posedge i_ref_clk);
         #1;
         k++;
      end while (!sig(sel) && k < 1000);
      do begin
         @(posedge i_ref_clk);
         #1;
         g++;
      end while (!sig(sel) && g < 1000);
   endtask
   task automatic quiet(input int sel, output int cnt);
      cnt = 0;
      repeat (300) begin
         @(posedge i_ref_clk);
         #1;
         if (sig(sel)) cnt++;
      end
   endtask
   task automatic wr(input logic [7:0] d);
      @(posedge i_ref_clk);
      i_ctrl_wr <= 1'b1;
      i_ctrl_wdata <= d;
      @(posedge i_ref_clk);
      i_ctrl_wr <= 1'b0;
      #1;
   endtask
   task automatic settle(input logic st);
      int k;
      k = 0;
      while (status !== st && k < 2000) begin
         @(posedge i_ref_clk);
         #1;
         k++;
      end
      repeat (4) gap(5, n);
   endtask
   task automatic t_reset();
      @(posedge i_ref_clk);
      #1;
      chk({7'h00, osc_en}, 8'h00, "osc during reset");
      chk(rdata, 8'h04, "reset value");
      repeat (2) @(posedge i_ref_clk);
      i_reset <= 1'b0;
      repeat (8) @(posedge i_ref_clk);
      #1;
      chk({status, wdt, osc_en}, 8'h03, "main after reset");
   endtask
   task automatic t_divide();
      wr(8'h00);
      gap(5, n);
      chk_n(n, 192, "old divide kept");
      for (int c = 0; c < 6; c++) begin
         wr(8'(c));
         settle(1'b0);
         gap(5, n);
         chk_n(n, 6 * (2 << ((c > 4) ? 4 : c)), "cpu divide");
      end
      for (int k = 0; k < 5; k++) begin
         gap(k, n);
         chk_n(n, 6 * (2 << k), "periph divide");
      end
      wr(8'h2c);
      chk(rdata, 8'h04, "masked bits");
      wr(8'h44);
      chk({rdata[7:1], frd}, 8'h45, "feedback off");
   endtask
   task automatic pulse(input int which);
      @(posedge i_ref_clk);
      if (which == 0) i_stop_req <= 1'b1;
      if (which == 1) i_halt_req <= 1'b1;
      if (which == 2) i_wake <= 1'b1;
      #1;
      if (which == 0) chk({7'h00, refused}, {7'h00, status}, "stop refusal");
      @(posedge i_ref_clk);
      {i_stop_req, i_halt_req, i_wake} <= 3'h0;
      #1;
   endtask
   task automatic t_sub();
      wr(8'h84);
      repeat (20) @(posedge i_ref_clk);
      #1;
      chk({osc_en, status}, 8'h02, "stop deferred");
      gap(0, n);
      chk_n(n, 12, "periph runs");
      wr(8'h94);
      settle(1'b1);
      chk({rdata[5], wdt}, 8'h02, "sub status");
      chk({osc_en, oe_n}, 8'h00, "main stopped");
      quiet(0, n);
      chk_n(n, 0, "periph halted");
      wr(8'h90);
      repeat (4) gap(5, n);
      chk_n(n, 40, "sub cpu rate");
      pulse(0);
      chk({stop_md, halt_md}, 8'h00, "stop refused");
      pulse(1);
      chk({stop_md, halt_md}, 8'h01, "halt on sub");
      quiet(5, n);
      chk_n(n, 0, "cpu halted");
      gap(6, n);
      chk_n(n, 40, "watch in standby");
      gap(7, n);
      chk_n(n, 40, "clkout in standby");
      pulse(2);
      chk({stop_md, halt_md}, 8'h00, "wake");
   endtask
   task automatic t_main_standby();
      wr(8'h04);
      settle(1'b0);
      chk({osc_en, wdt}, 8'h03, "main back");
      pulse(0);
      chk({stop_md, osc_en, oe_n}, 8'h04, "stop on main");
      quiet(0, n);
      chk_n(n, 0, "periph in stop");
      pulse(2);
      pulse(1);
      chk({stop_md, halt_md, osc_en}, 8'h03, "halt on main");
      pulse(2);
   endtask
   initial begin
      t_reset();
      t_divide();
      t_sub();
      t_main_standby();
      wrap_up();
   end
endmodule
